// [verilog/fcs_regs.sv]
/*
 * fcs_regs: register bank and fan drive of the temperature monitor and fan controller.
 * assumes conversion results and the over-limit flag come from logic on clk;
 * the over-temperature line is an asynchronous pin seen here as an input level.
 */
// Implementation choice: the strobed register port.
`timescale 1ns/1ps

// Functional notes
// [RL1] local over-temp sets status bit 6 once; read clears; no reassert while persisting
// [RL2] over-temp line pulled low sets status bit 7; read of status clears it
// [RL3] over-temp line low forces full fan speed regardless of programmed speed
// [RL4] fraction register: remote bits 2..0, local bits 7..6, bits 5..3 zero
// [RL5] spin-up time code 0..7: 200,400,600,800 ms, 1,2,4,8 s; default 5
// [RL6] drive frequency code 0..7: 11.7 to 93.5 Hz; default code 3
// [RL7] speed range divisor 1,2,4,8 with fail thresholds 2647,1324,662,331 RPM
// [RL8] speed nibble is normal speed in software mode, minimum in auto mode
// [RL9] filter register bit 7 set skips the spin-up interval
// [RL10] ramp rate code selects duty step of 1, 2, 4 or 8
// [RL11] sample rate code 0..7 from 87.5 Hz doubling to 11.2 kHz; default 4
// [RL12] filter register bit 0 enables filtering of the drive output
// [RL13] local start temperature is 5-bit field times 4 degrees, default 32
// [RL14] local span code 0..4 selects 5,10,20,40,80 degrees, default 10
// [RL15] control bit 7 selects automatic control, zero selects software speed
// [RL16] auto: minimum speed below start, rising to full speed across the span
// [RL17] status bits 5..0 read zero and ignore writes
module fcs_regs #(
    parameter int unsigned SPIN_UNIT_CYC = fcs_pkg::SPIN_UNIT_CYC,
    parameter int unsigned ADC_BASE_CYC  = fcs_pkg::ADC_BASE_CYC,
    parameter int unsigned DRIVE_CLK_HZ  = fcs_pkg::CLK_HZ
) (
    input  wire logic        clk,
    input  wire logic        rst_n,
    input  wire logic        clk_en,
    input  wire logic [7:0]  reg_addr,
    input  wire logic [7:0]  reg_wdata,
    input  wire logic        reg_wr,
    input  wire logic        reg_rd,
    output logic      [7:0]  reg_rdata,
    output logic             irq,
    input  wire logic [7:0]  local_temp,
    input  wire logic [1:0]  local_frac,
    input  wire logic [2:0]  remote_frac,
    input  wire logic        local_over_limit,
    input  wire logic        therm_pin_n,
    output logic             fan_drive,
    output logic             adc_sample_tick,
    output logic      [3:0]  speed_range_div,
    output logic      [11:0] fail_rpm_thresh
);

    // ------------
    // registers
    // ------------
    logic [7:0]  status_two;
    logic [7:0]  fan_characteristics;
    logic [7:0]  fan_speed_setting;
    logic [7:0]  fan_filter_control;
    logic [7:0]  local_start_and_span;
    logic [7:0]  fan_control;
    logic [7:0]  irq_enable;

    fcs_pkg::fcs_fan_char_s   fan_char;
    fcs_pkg::fcs_filter_s     filt;
    fcs_pkg::fcs_start_span_s start_span;

    assign fan_char   = fcs_pkg::fcs_fan_char_s'(fan_characteristics);
    assign filt       = fcs_pkg::fcs_filter_s'(fan_filter_control);
    assign start_span = fcs_pkg::fcs_start_span_s'(local_start_and_span);

    // ------------
    // address decode
    // ------------
    wire sel_status  = (reg_addr == fcs_pkg::OFS_STATUS_TWO);
    wire sel_frac    = (reg_addr == fcs_pkg::OFS_TEMP_FRAC);
    wire sel_char    = (reg_addr == fcs_pkg::OFS_FAN_CHAR);
    wire sel_speed   = (reg_addr == fcs_pkg::OFS_FAN_SPEED);
    wire sel_filter  = (reg_addr == fcs_pkg::OFS_FAN_FILTER);
    wire sel_start   = (reg_addr == fcs_pkg::OFS_LOCAL_START);
    wire sel_control = (reg_addr == fcs_pkg::OFS_FAN_CONTROL);
    wire sel_enable  = (reg_addr == fcs_pkg::OFS_IRQ_ENABLE);
    wire sel_clear   = (reg_addr == fcs_pkg::OFS_IRQ_CLEAR);
    wire rd_status   = reg_rd & sel_status;

    // read mux; unmapped and write-only offsets read zero
    wire [7:0] frac_view = {local_frac, 3'b000, remote_frac};                    // [RL4]
    wire [7:0] next_rdata =
        sel_status  ? (status_two & fcs_pkg::STATUS_USED_MASK) :                 // [RL17]
        sel_frac    ? frac_view :
        sel_char    ? fan_characteristics :
        sel_speed   ? (fan_speed_setting & fcs_pkg::SPEED_USED_MASK) :
        sel_filter  ? fan_filter_control :
        sel_start   ? local_start_and_span :
        sel_control ? fan_control :
        sel_enable  ? irq_enable : 8'h00;

    // ------------
    // over-temperature line synchroniser and event flags
    // ------------
    logic therm_s1;
    logic therm_s2;
    logic loc_over_q;

    // pin is asynchronous: two stages before anything looks at it
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            therm_s1   <= 1'b1;
            therm_s2   <= 1'b1;
            loc_over_q <= 1'b0;
        end
        else if (clk_en)
        begin
            therm_s1   <= therm_pin_n;
            therm_s2   <= therm_s1;
            loc_over_q <= local_over_limit;
        end
    end

    wire       therm_low = ~therm_s2;
    // edge only, so a persisting condition does not set the flag again after a read
    wire       loc_set   = local_over_limit & ~loc_over_q; // [RL1]
    wire [7:0] clr_bits  = (rd_status ? fcs_pkg::STATUS_USED_MASK : 8'h00) |
                           ((reg_wr & sel_clear) ? reg_wdata : 8'h00);
    wire [7:0] set_bits  = {therm_low, loc_set, 6'b000000};                      // [RL2]
    // set wins over a clear in the same cycle
    wire [7:0] next_status = (set_bits | (status_two & ~clr_bits)) & fcs_pkg::STATUS_USED_MASK;
    wire       next_irq    = |(next_status & irq_enable);

    // ------------
    // register writes, status and read data
    // ------------
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            fan_characteristics  <= fcs_pkg::RST_FAN_CHAR;
            fan_speed_setting    <= fcs_pkg::RST_FAN_SPEED;
            fan_filter_control   <= fcs_pkg::RST_FAN_FILTER;
            local_start_and_span <= fcs_pkg::RST_LOCAL_START;
            fan_control          <= fcs_pkg::RST_FAN_CONTROL;
            irq_enable           <= fcs_pkg::RST_IRQ_ENABLE;
        end
        else if (clk_en && reg_wr)
        begin
            if (sel_char)    fan_characteristics  <= reg_wdata;
            if (sel_speed)   fan_speed_setting    <= reg_wdata & fcs_pkg::SPEED_USED_MASK;
            if (sel_filter)  fan_filter_control   <= reg_wdata;
            if (sel_start)   local_start_and_span <= reg_wdata;
            if (sel_control) fan_control          <= reg_wdata;
            if (sel_enable)  irq_enable           <= reg_wdata;
        end
    end

    // status is read-to-clear; the read returns the value before clearing
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            status_two <= fcs_pkg::RST_STATUS_TWO;
            reg_rdata  <= 8'h00;
            irq        <= 1'b0;
        end
        else if (clk_en)
        begin
            status_two <= next_status; // [RL1] [RL2]
            reg_rdata  <= reg_rd ? next_rdata : 8'h00;
            irq        <= next_irq;
        end
    end

    // ------------
    // speed range outputs
    // ------------
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            speed_range_div <= 4'h1;
            fail_rpm_thresh <= 12'h000;
        end
        else if (clk_en)
        begin
            speed_range_div <= 4'(4'h1 << fan_char.speed_range);                 // [RL7]
            fail_rpm_thresh <= fcs_pkg::FAIL_RPM[fan_char.speed_range];          // [RL7]
        end
    end

    // ------------
    // converter sampling tick
    // ------------
    logic [19:0] adc_cnt;
    wire  [19:0] adc_period = 20'(ADC_BASE_CYC >> filt.sample_rate);            // [RL11]
    wire         adc_wrap   = (adc_cnt >= adc_period - 20'h00001);

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            adc_cnt         <= 20'h00000;
            adc_sample_tick <= 1'b0;
        end
        else if (clk_en)
        begin
            adc_cnt         <= adc_wrap ? 20'h00000 : adc_cnt + 20'h00001;
            adc_sample_tick <= adc_wrap;
        end
    end

    // ------------
    // automatic control target
    // ------------
    // span 5 << k is divided by multiplying by 13/64 and shifting by k,
    // trading under 2% of slope error for a divider-free datapath
    wire [7:0]  min_duty   = {fan_speed_setting[3:0], 4'h0};                    // [RL8]
    wire [7:0]  start_deg  = {1'b0, start_span.start_temp, 2'b00};              // [RL13]
    wire [2:0]  span_code  = (start_span.span > 3'h4) ? 3'h4 : start_span.span;
    wire [7:0]  span_deg   = 8'(8'h05 << span_code); // [RL14]
    wire        above      = (local_temp > start_deg);
    wire [7:0]  delta      = local_temp - start_deg;
    wire [7:0]  headroom   = fcs_pkg::DUTY_FULL - min_duty;
    wire [19:0] ramp_prod  = 20'(delta * headroom) * 20'h0000D;
    wire [19:0] ramp_add   = ramp_prod >> (5'd6 + 5'(span_code));
    wire [7:0]  auto_duty  = !above ? min_duty : // [RL16]
                             (delta >= span_deg) ? fcs_pkg::DUTY_FULL :
                             8'(min_duty + ramp_add[7:0]);
    wire        auto_mode  = fan_control[fcs_pkg::BIT_CTRL_SOURCE];
    wire [7:0]  target     = auto_mode ? auto_duty : min_duty;                   // [RL15]

    // ------------
    // drive period timing
    // ------------
    logic [15:0] slot_div;
    logic [7:0]  slot;
    wire  [15:0] slot_cyc  = 16'((64'(DRIVE_CLK_HZ) * 64'd1000) /
                                 (64'(fcs_pkg::PWM_MHZ[fan_char.drive_freq]) * 64'd240)); // [RL6]
    wire         slot_end  = (slot_div >= slot_cyc - 16'h0001);
    wire         period_end = slot_end && (slot == fcs_pkg::DUTY_FULL - 8'h01);

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            slot_div <= 16'h0000;
            slot     <= 8'h00;
        end
        else if (clk_en)
        begin
            slot_div <= slot_end ? 16'h0000 : slot_div + 16'h0001;
            if (slot_end)
                slot <= period_end ? 8'h00 : slot + 8'h01;
        end
    end

    // ------------
    // ramped duty
    // ------------
    logic [7:0] duty_now;
    wire  [7:0] step      = 8'(8'h01 << filt.ramp_rate); // [RL10]
    wire  [8:0] up_sum    = {1'b0, duty_now} + {1'b0, step};
    wire  [7:0] next_up   = (up_sum[7:0] > target || up_sum[8]) ? target : up_sum[7:0];
    wire  [7:0] next_down = (duty_now < target + step) ? target : duty_now - step;
    wire  [7:0] next_duty = therm_low ? fcs_pkg::DUTY_FULL :                    // [RL3]
                            !period_end ? duty_now :
                            (duty_now < target) ? next_up :
                            (duty_now > target) ? next_down : duty_now;

    // ramp once per drive period; the over-temperature line bypasses the ramp
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            duty_now <= 8'h00;
        else if (clk_en)
            duty_now <= next_duty;
    end

    // ------------
    // spin-up
    // ------------
    logic [5:0]  spin_units;
    logic [23:0] spin_cyc;
    wire         spinning  = (spin_units != 6'h00);
    wire         fan_start = (duty_now == 8'h00) && (next_duty != 8'h00);
    wire         unit_end  = (spin_cyc >= 24'(SPIN_UNIT_CYC) - 24'h000001);

    // a fan starting from rest runs full for the spin-up time to beat its inertia
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            spin_units <= 6'h00;
            spin_cyc   <= 24'h000000;
        end
        else if (clk_en)
        begin
            if (fan_start && !filt.spin_up_disable) // [RL9]
            begin
                spin_units <= fcs_pkg::SPIN_UNITS[fan_char.spin_up];             // [RL5]
                spin_cyc   <= 24'h000000;
            end
            else if (spinning)
            begin
                spin_cyc <= unit_end ? 24'h000000 : spin_cyc + 24'h000001;
                if (unit_end)
                    spin_units <= spin_units - 6'h01;
            end
        end
    end

    // ------------
    // drive output and filter
    // ------------
    logic       raw_q;
    wire  [7:0] duty_eff  = (spinning || therm_low) ? fcs_pkg::DUTY_FULL : duty_now; // [RL3]
    wire        raw_drive = (slot < duty_eff);
    // filter: a change reaches the output once the slot-start sample agrees, a cycle late; slivers are removed only when a slot is one cycle
    wire        next_drive = filt.filter_en ? // [RL12]
                             ((raw_drive == raw_q) ? raw_drive : fan_drive) : raw_drive;

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            raw_q     <= 1'b0;
            fan_drive <= 1'b0;
        end
        else if (clk_en)
        begin
            if (slot_div == 16'h0000)
                raw_q <= raw_drive;
            fan_drive <= next_drive;
        end
    end

endmodule

// [verilog/fcs_pkg.sv]
/*
 * fcs_pkg: shared constants and types of the fan control and status register bank.
 * assumes a single 50 MHz clock and an 8-bit register port with byte-wide registers.
 */
package fcs_pkg;

    // ------------
    // register offsets
    // ------------
    localparam logic [7:0] OFS_STATUS_TWO   = 8'h03;
    localparam logic [7:0] OFS_TEMP_FRAC    = 8'h06;
    localparam logic [7:0] OFS_FAN_CHAR     = 8'h20;
    localparam logic [7:0] OFS_FAN_SPEED    = 8'h22;
    localparam logic [7:0] OFS_FAN_FILTER   = 8'h23;
    localparam logic [7:0] OFS_LOCAL_START  = 8'h24;
    localparam logic [7:0] OFS_FAN_CONTROL  = 8'h40;
    localparam logic [7:0] OFS_IRQ_ENABLE   = 8'h41;
    localparam logic [7:0] OFS_IRQ_CLEAR    = 8'h42;

    // ------------
    // reset values and field positions
    // ------------
    localparam logic [7:0] RST_STATUS_TWO   = 8'h00;
    localparam logic [7:0] RST_FAN_CHAR     = 8'h5D;
    localparam logic [7:0] RST_FAN_SPEED    = 8'h05;
    localparam logic [7:0] RST_FAN_FILTER   = 8'h50;
    localparam logic [7:0] RST_LOCAL_START  = 8'h41;
    localparam logic [7:0] RST_FAN_CONTROL  = 8'h80;
    localparam logic [7:0] RST_IRQ_ENABLE   = 8'h00;
    localparam int         BIT_LOC_THERM    = 6;
    localparam int         BIT_THERM_IN     = 7;
    localparam int         BIT_CTRL_SOURCE  = 7;
    localparam logic [7:0] STATUS_USED_MASK = 8'hC0;
    localparam logic [7:0] SPEED_USED_MASK  = 8'h0F;

    // ------------
    // duty scale, timing and lookup tables
    // ------------
    localparam logic [7:0]  DUTY_FULL       = 8'hF0;   // 240 slots per drive period
    localparam int unsigned CLK_HZ          = 50_000_000;
    localparam int unsigned SPIN_UNIT_MS    = 200;
    localparam int unsigned SPIN_UNIT_CYC   = CLK_HZ / 1000 * SPIN_UNIT_MS;
    localparam int unsigned ADC_BASE_MHZ    = 87_500;  // slowest sampling rate in mHz
    localparam int unsigned ADC_BASE_CYC    = 32'((64'(CLK_HZ) * 64'd1000) / 64'(ADC_BASE_MHZ));
    localparam logic [5:0]  SPIN_UNITS [8]  = '{6'h01, 6'h02, 6'h03, 6'h04, 6'h05, 6'h0A, 6'h14, 6'h28};
    localparam int unsigned PWM_MHZ    [8]  = '{11_700, 15_600, 23_400, 31_250, 37_500, 46_900, 62_500, 93_500};
    localparam logic [11:0] FAIL_RPM   [4]  = '{12'hA57, 12'h52C, 12'h296, 12'h14B};

    // ------------
    // register field overlays
    // ------------
    typedef struct packed {
        logic [1:0] speed_range;
        logic [2:0] drive_freq;
        logic [2:0] spin_up;
    } fcs_fan_char_s;

    typedef struct packed {
        logic       spin_up_disable;
        logic [1:0] ramp_rate;
        logic [2:0] sample_rate;
        logic       spare;
        logic       filter_en;
    } fcs_filter_s;

    typedef struct packed {
        logic [4:0] start_temp;
        logic [2:0] span;
    } fcs_start_span_s;

endpackage

// [tb/fcs_regs_props.sv]
/*
 * fcs_regs_props: port assertions for the fan control register bank.
 * assumes one clock, the bank's async active-low reset and clk_en held high.
 */
`timescale 1ns/1ps
module fcs_regs_props (
    input wire logic        clk,
    input wire logic        rst_n,
    input wire logic        clk_en,
    input wire logic [7:0]  reg_addr,
    input wire logic [7:0]  reg_wdata,
    input wire logic        reg_wr,
    input wire logic        reg_rd,
    input wire logic [7:0]  reg_rdata,
    input wire logic        irq,
    input wire logic [7:0]  local_temp,
    input wire logic [1:0]  local_frac,
    input wire logic [2:0]  remote_frac,
    input wire logic        local_over_limit,
    input wire logic        therm_pin_n,
    input wire logic        fan_drive,
    input wire logic        adc_sample_tick,
    input wire logic [3:0]  speed_range_div,
    input wire logic [11:0] fail_rpm_thresh
);
    // ------------
    // offset decode
    // ------------
    // the clear offset is write-only, so it is left out of the readable set
    wire       rd_map = reg_addr inside {8'h03, 8'h06, 8'h20, 8'h22, 8'h23, 8'h24, 8'h40, 8'h41};
    wire       wr_rw  = reg_addr inside {8'h20, 8'h22, 8'h23, 8'h24, 8'h40, 8'h41};
    wire [7:0] wmask  = (reg_addr == 8'h22) ? 8'h0F : 8'hFF;

    // ------------
    // properties
    // ------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    a_rdata_idle: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00)
        else $error("read data not zero outside the read slot");
    a_unmapped_zero: assert property (reg_rd && !rd_map |=> reg_rdata == 8'h00)
        else $error("unreadable offset returned data");
    a_status_unused: assert property (reg_rd && reg_addr == 8'h03 |=> reg_rdata[5:0] == 6'h00)
        else $error("status low bits not zero");
    a_frac_read: assert property (reg_rd && reg_addr == 8'h06
        |=> reg_rdata == {$past(local_frac), 3'h0, $past(remote_frac)}) else $error("fraction bits misplaced");
    a_wr_readback: assert property (reg_wr && wr_rw ##1 reg_rd && reg_addr == $past(reg_addr)
        |=> reg_rdata == ($past(reg_wdata, 2) & $past(wmask, 2))) else $error("written value not read back");
    a_loc_noreassert: assert property ((reg_rd && reg_addr == 8'h03 && $stable(local_over_limit)) [*2]
        |=> !reg_rdata[6]) else $error("local flag set again while condition held");
    a_therm_full: assert property ((!therm_pin_n && clk_en) [*6] |-> fan_drive)
        else $error("fan not at full drive while line held low");
    a_tick_pulse: assert property (adc_sample_tick |=> !adc_sample_tick)
        else $error("sample tick longer than one cycle");
    // past reset only: the first edge after release still samples reset values
    a_range_pair: assert property ($past(rst_n) |->
        (speed_range_div == 4'h1 && fail_rpm_thresh == 12'hA57) || (speed_range_div == 4'h2 && fail_rpm_thresh == 12'h52C)
        || (speed_range_div == 4'h4 && fail_rpm_thresh == 12'h296) || (speed_range_div == 4'h8 && fail_rpm_thresh == 12'h14B))
        else $error("speed range and fail threshold disagree");
endmodule

bind fcs_regs fcs_regs_props u_props (
    .clk(clk), .rst_n(rst_n), .clk_en(clk_en), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .irq(irq), .local_temp(local_temp), .local_frac(local_frac),
    .remote_frac(remote_frac), .local_over_limit(local_over_limit), .therm_pin_n(therm_pin_n),
    .fan_drive(fan_drive), .adc_sample_tick(adc_sample_tick), .speed_range_div(speed_range_div),
    .fail_rpm_thresh(fail_rpm_thresh)
);

// [tb/fcs_sensor_model.sv]
/*
 * fcs_sensor_model: converter results and over-temperature line beside the bank.
 * assumes the bench sets the readings; results change only on a sample tick.
 */
`timescale 1ns/1ps
module fcs_sensor_model (
    input wire logic       clk,
    input wire logic       rst_n,
    input wire logic       adc_sample_tick,
    input wire logic [7:0] temp_cmd,
    input wire logic [1:0] lfrac_cmd,
    input wire logic [2:0] rfrac_cmd,
    input wire logic       over_cmd,
    input wire logic       therm_pull,
    output logic     [7:0] local_temp,
    output logic     [1:0] local_frac,
    output logic     [2:0] remote_frac,
    output logic           local_over_limit,
    output logic           therm_pin_n
);
    // results publish only at a sample instant, so the bank sees stale values between ticks
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            {local_temp, local_frac, remote_frac, local_over_limit} <= 14'h0000;
        else if (adc_sample_tick)
            {local_temp, local_frac, remote_frac, local_over_limit} <= {temp_cmd, lfrac_cmd, rfrac_cmd, over_cmd};
    end

    // open-drain line with a pull-up: released reads high
    assign therm_pin_n = therm_pull ? 1'b0 : 1'b1;
endmodule

// [tb/test_fan_control_status_regs.sv]
/*
 * test_fan_control_status_regs: self-checking bench for the fan control register bank.
 * assumes shortened spin-up, sample and drive counts passed in as parameters.
 */
`timescale 1ns/1ps
module test_fan_control_status_regs;
    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] rst;
        logic [7:0] wdata;
        logic [7:0] exp;
    } fcs_row_s;
    // ------------
    // signals and tables
    // ------------
    logic        clk = 1'b0, rst_n = 1'b0, clk_en = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0;
    logic [7:0]  reg_addr = 8'h00, reg_wdata = 8'h00, temp_cmd = 8'h00, d0, d1;
    logic [1:0]  lfrac_cmd = 2'h0;
    logic [2:0]  rfrac_cmd = 3'h0;
    logic        over_cmd = 1'b0, therm_pull = 1'b0;
    logic [11:0] h;
    int          n_errors = 0, n_compared = 0, cycles = 0;
    wire  [7:0]  reg_rdata, local_temp;
    wire  [3:0]  speed_range_div;
    wire  [11:0] fail_rpm_thresh;
    wire  [1:0]  local_frac;
    wire  [2:0]  remote_frac;
    wire         irq, fan_drive, adc_sample_tick, local_over_limit, therm_pin_n;
    logic [11:0] rpm [4] = '{12'hA57, 12'h52C, 12'h296, 12'h14B};
    // offset, reset value, value written, value read back
    fcs_row_s    rows [10] = '{'{8'h03, 8'h00, 8'hFF, 8'h00}, '{8'h06, 8'h00, 8'hFF, 8'h00},
        '{8'h20, 8'h5D, 8'hFA, 8'hFA}, '{8'h22, 8'h05, 8'hFF, 8'h0F}, '{8'h23, 8'h50, 8'hEC, 8'hEC},
        '{8'h24, 8'h41, 8'hBC, 8'hBC}, '{8'h40, 8'h80, 8'h00, 8'h00}, '{8'h41, 8'h00, 8'hC0, 8'hC0},
        '{8'h42, 8'h00, 8'hFF, 8'h00}, '{8'h10, 8'h00, 8'hFF, 8'h00}};

    // drive slot of one cycle at the fastest frequency, so a drive period is 240 cycles
    fcs_regs #(.SPIN_UNIT_CYC(100), .ADC_BASE_CYC(256), .DRIVE_CLK_HZ(24000)) uut (.clk(clk), .rst_n(rst_n),
        .clk_en(clk_en), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .irq(irq), .local_temp(local_temp), .local_frac(local_frac),
        .remote_frac(remote_frac), .local_over_limit(local_over_limit), .therm_pin_n(therm_pin_n),
        .fan_drive(fan_drive), .adc_sample_tick(adc_sample_tick), .speed_range_div(speed_range_div),
        .fail_rpm_thresh(fail_rpm_thresh));
    fcs_sensor_model partner (.clk(clk), .rst_n(rst_n), .adc_sample_tick(adc_sample_tick), .temp_cmd(temp_cmd),
        .lfrac_cmd(lfrac_cmd), .rfrac_cmd(rfrac_cmd), .over_cmd(over_cmd), .therm_pull(therm_pull),
        .local_temp(local_temp), .local_frac(local_frac), .remote_frac(remote_frac),
        .local_over_limit(local_over_limit), .therm_pin_n(therm_pin_n));

    // ------------
    // tasks: every task that waits on the clock starts and ends on a rising edge
    // ------------
    task automatic chk(input string what, input logic [11:0] seen, input logic [11:0] exp);
        n_compared = n_compared + 1;
        if (seen !== exp)
        begin
            $display("mismatch %s expected %h seen %h", what, exp, seen);
            n_errors = n_errors + 1;
        end
    endtask
    // leaves the strobe low at the final edge, so a read may follow with no gap
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        {reg_addr, reg_wdata, reg_wr} <= {a, d, 1'b1};
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask
    task automatic wrg(input logic [7:0] a, input logic [7:0] d);
        wr(a, d);
        @(posedge clk);
    endtask
    // two reads back to back: the second shows what the first one cleared
    task automatic rd2(input logic [7:0] a, output logic [7:0] r0, output logic [7:0] r1);
        {reg_addr, reg_rd} <= {a, 1'b1};
        @(posedge clk);
        #1 r0 = reg_rdata;
        @(posedge clk);
        reg_rd <= 1'b0;
        #1 r1 = reg_rdata;
        @(posedge clk);
    endtask
    // counts high samples of the drive or of the tick over n cycles
    task automatic count(input bit tick, input int n, output logic [11:0] c);
        c = 12'h000;
        repeat (n)
        begin
            @(posedge clk);
            #1 c = c + 12'((tick ? adc_sample_tick : fan_drive) === 1'b1);
        end
        @(posedge clk);
    endtask
    task automatic tally_and_finish();
        if (n_errors == 0 && n_compared > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask

    // ------------
    // clock, guard and sequence
    // ------------
    always #10 clk = ~clk;
    // the sequence needs about 60000 cycles; a hang ends as a failure
    always @(posedge clk)
    begin
        cycles <= cycles + 1;
        if (cycles == 90000)
        begin
            n_errors = n_errors + 1;
            tally_and_finish();
        end
    end
    initial
    begin
        repeat (6) @(posedge clk);
        rst_n <= 1'b1;
        repeat (3) @(posedge clk);
        #1 chk("range div", {8'h00, speed_range_div}, 12'h002);
        chk("fail rpm", fail_rpm_thresh, 12'h52C);
        @(posedge clk);
        foreach (rows[i])
        begin
            rd2(rows[i].addr, d0, d1);
            chk("reset value", {4'h0, d0}, {4'h0, rows[i].rst});
            wr(rows[i].addr, rows[i].wdata);
            rd2(rows[i].addr, d0, d1);
            chk("read back", {4'h0, d1}, {4'h0, rows[i].exp});
        end
        for (int c = 0; c < 4; c++)
        begin
            wrg(8'h20, {c[1:0], 6'h3A});
            #1 chk("range div", {8'h00, speed_range_div}, 12'h001 << c);
            chk("fail rpm", fail_rpm_thresh, rpm[c]);
            @(posedge clk);
        end
        // 512 cycles hold a whole number of tick periods at every code, so phase does not matter
        for (int c = 0; c < 8; c++)
        begin
            wrg(8'h23, {3'h7, c[2:0], 2'h0});
            repeat (300) @(posedge clk);
            count(1'b1, 512, h);
            chk("ticks", h, 12'h002 << c);
        end
        wrg(8'h23, 8'hEC);
        {lfrac_cmd, rfrac_cmd, over_cmd} <= {2'h2, 3'h5, 1'b1};
        repeat (70) @(posedge clk);
        #1 chk("irq", {11'h000, irq}, 12'h001);
        @(posedge clk);
        rd2(8'h06, d0, d1);
        chk("fraction", {4'h0, d0}, 12'h085);
        rd2(8'h03, d0, d1);
        chk("local flag", {d0[7:4], d1}, 12'h400);
        repeat (70) @(posedge clk);
        rd2(8'h03, d0, d1);
        over_cmd <= 1'b0;
        #1 chk("held flag and irq", {3'h0, irq, d0}, 12'h000);
        @(posedge clk);
        wrg(8'h22, 8'h05);
        repeat (8000) @(posedge clk);
        count(1'b0, 240, h);
        chk("sw duty", h, 12'h050);
        wrg(8'h22, 8'h00);
        repeat (8000) @(posedge clk);
        therm_pull <= 1'b1;
        repeat (10) @(posedge clk);
        count(1'b0, 240, h);
        chk("forced duty", h, 12'h0F0);
        therm_pull <= 1'b0;
        #1 chk("irq", {11'h000, irq}, 12'h001);
        repeat (10) @(posedge clk);
        rd2(8'h03, d0, d1);
        chk("line flag", {d0[7:4], d1}, 12'h800);
        repeat (8000) @(posedge clk);
        wrg(8'h22, 8'h05);
        count(1'b0, 480, h);
        chk("no spin-up", {11'h000, h < 12'h0F0}, 12'h001);
        wrg(8'h22, 8'h00);
        repeat (8000) @(posedge clk);
        wrg(8'h23, 8'h6D);
        wrg(8'h22, 8'h05);
        for (int k = 0; k < 300 && fan_drive !== 1'b1; k++) @(posedge clk);
        count(1'b0, 240, h);
        chk("spin-up", h, 12'h0F0);
        wrg(8'h24, 8'h41);
        temp_cmd <= 8'h20;
        wrg(8'h40, 8'h80);
        repeat (8000) @(posedge clk);
        count(1'b0, 240, h);
        chk("auto at start", h, 12'h050);
        temp_cmd <= 8'h2A;
        repeat (8000) @(posedge clk);
        count(1'b0, 240, h);
        chk("auto span end", h, 12'h0F0);
        tally_and_finish();
    end
endmodule
